//--- core/code_bank_reset_select.v
/*
  code bank overlay selection and reset source handling: decides
  whether low code space comes from the boot block, tracks the
  soft-reset and bank-select bits across all reset kinds, filters
  brownout, and keeps the power-on flag. avalon-mm slave registers.
  assumes RST_I is the power-on reset, the reset pin and supply-low
  inputs are asynchronous, and the watchdog pulse is on CLK_I.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bank_consts.vh"

module code_bank_reset_select #(
  parameter BO_MIN = `BO_MIN_CYCLES
) (
  input wire CLK_I,
  input wire RST_I,
  input wire RST_PIN_I,
  input wire SUPPLY_LOW_I,
  input wire WDOG_RESET_I,
  input wire [15:0] FETCH_ADDR_I,
  input wire [7:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O,
  output reg FETCH_BOOT_O,
  output reg [8:0] FETCH_SECTOR_O,
  output reg CPU_RESET_O,
  output reg BO_IRQ_O,
  output reg IRQ_O
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg soft_reset_bit_ff;
  reg bank_select_bit_ff;
  reg power_on_flag_ff;
  reg brownout_irq_enable_ff;
  reg [7:0] wdog_ctrl_ff;
  reg [4:0] irq_sts_ff;
  reg [4:0] irq_en_ff;
  reg bo_prev_ff;
  reg nxt_soft_reset_bit;
  reg nxt_bank_select_bit;
  reg nxt_power_on_flag;
  reg nxt_brownout_irq_enable;
  reg [7:0] nxt_wdog_ctrl;
  reg [4:0] nxt_irq_sts;
  reg [4:0] nxt_irq_en;
  reg [31:0] nxt_rdata;
  wire ext_lvl;
  wire low_lvl;
  wire bo_det;
  wire req;
  wire take;
  wire wr_take;
  wire [5:0] widx;
  wire wr_cfg;
  wire wr_power;
  wire wr_ien;
  wire wr_wdog;
  wire bo_rise;
  wire en_drop;
  wire bo_reset;
  wire sw_reset;
  wire hw_keep_reset;
  wire [4:0] events;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // boot block overlays the low 8 kB only with both bits clear
  function boot_sel;
    input [15:0] addr;
    input soft_bit;
    input bank_bit;
    begin
      boot_sel = (addr <= `BOOT_TOP) && !soft_bit && !bank_bit;
    end
  endfunction

  // word index of a byte address; unaligned low bits are ignored
  function [5:0] word_idx;
    input [7:0] addr;
    begin
      word_idx = addr[7:2];
    end
  endfunction

  // ---------------------------------------------------------------
  // input conditioning
  // ---------------------------------------------------------------
  // the reset pin is only sampled, so a pulse not seen high at two
  // successive edges is lost; the external circuit must stretch it
  pin_sync #(
    .RST_VAL(1'b0)
  ) u_pin_rst (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(RST_PIN_I),
    .level_o(ext_lvl)
  );

  pin_sync #(
    .RST_VAL(1'b0)
  ) u_pin_low (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(SUPPLY_LOW_I),
    .level_o(low_lvl)
  );

  // supply-low must persist before anything reacts
  bo_filter #(
    .MIN_CYCLES(BO_MIN)
  ) u_bo_filter (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .low_i(low_lvl),
    .det_o(bo_det)
  );

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // one wait state: a request is taken in its second cycle
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign take = req & ~AVS_WAITREQUEST_O;
  assign wr_take = take & AVS_WRITE_I;
  assign widx = word_idx(AVS_ADDRESS_I);
  assign wr_cfg = wr_take && (widx == `OFF_FLASH_CFG);
  assign wr_power = wr_take && (widx == `OFF_POWER_CTRL);
  assign wr_ien = wr_take && (widx == `OFF_IRQ_EN_ONE);
  assign wr_wdog = wr_take && (widx == `OFF_WDOG_CTRL);

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------
  assign bo_rise = bo_det & ~bo_prev_ff;
  // software drops the enable while the supply is still low
  assign en_drop = wr_ien & brownout_irq_enable_ff
    & ~AVS_WRITEDATA_I[`FLD_BO_IRQ_EN];
  assign bo_reset = (bo_rise & ~brownout_irq_enable_ff)
    | (en_drop & bo_det);
  // only a rising edge of the written bit counts
  assign sw_reset = wr_cfg & AVS_WRITEDATA_I[`FLD_SOFT_RST]
    & ~soft_reset_bit_ff;
  assign hw_keep_reset = bo_reset | WDOG_RESET_I;

  assign events = {ext_lvl, sw_reset & ~ext_lvl,
    WDOG_RESET_I & ~ext_lvl, bo_reset & ~ext_lvl,
    bo_rise & brownout_irq_enable_ff};

  // ---------------------------------------------------------------
  // bank bits next state
  // ---------------------------------------------------------------
  // pin reset first, then brownout or watchdog, then software;
  // a software write racing a hardware reset is dropped
  always @* begin
    nxt_soft_reset_bit = soft_reset_bit_ff;
    nxt_bank_select_bit = bank_select_bit_ff;
    if (ext_lvl) begin
      nxt_soft_reset_bit = 1'b0;
      nxt_bank_select_bit = 1'b0;
    end else if (hw_keep_reset) begin
      nxt_bank_select_bit = 1'b0;
    end else if (sw_reset) begin
      nxt_soft_reset_bit = 1'b1;
      nxt_bank_select_bit = 1'b0;
    end else if (wr_cfg) begin
      nxt_soft_reset_bit = AVS_WRITEDATA_I[`FLD_SOFT_RST];
      nxt_bank_select_bit = AVS_WRITEDATA_I[`FLD_BANK_SEL];
    end
  end

  // ---------------------------------------------------------------
  // control registers next state
  // ---------------------------------------------------------------
  // every running reset returns the brownout enable and watchdog control to
  // reset values, except the kept watchdog bit on a software reset
  always @* begin
    nxt_power_on_flag = power_on_flag_ff;
    nxt_brownout_irq_enable = brownout_irq_enable_ff;
    nxt_wdog_ctrl = wdog_ctrl_ff;
    // other resets leave the power-on flag alone
    if (wr_power && !AVS_WRITEDATA_I[`FLD_POWER_ON]) begin
      nxt_power_on_flag = 1'b0;
    end
    if (ext_lvl || hw_keep_reset) begin
      nxt_brownout_irq_enable = 1'b0;
      nxt_wdog_ctrl = `RST_WDOG_CTRL;
    end else if (sw_reset) begin
      nxt_brownout_irq_enable = 1'b0;
      nxt_wdog_ctrl = `RST_WDOG_CTRL;
      nxt_wdog_ctrl[`FLD_WDOG_KEEP] =
        wdog_ctrl_ff[`FLD_WDOG_KEEP];
    end else begin
      if (wr_ien) begin
        nxt_brownout_irq_enable = AVS_WRITEDATA_I[`FLD_BO_IRQ_EN];
      end
      if (wr_wdog) begin
        nxt_wdog_ctrl = AVS_WRITEDATA_I[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status next state
  // ---------------------------------------------------------------
  // a new event in the clearing cycle survives the clear
  always @* begin
    nxt_irq_sts = irq_sts_ff;
    nxt_irq_en = irq_en_ff;
    if (wr_take && (widx == `OFF_IRQ_CLEAR)) begin
      nxt_irq_sts = irq_sts_ff & ~AVS_WRITEDATA_I[4:0];
    end
    nxt_irq_sts = nxt_irq_sts | events;
    if (wr_take && (widx == `OFF_IRQ_ENABLE)) begin
      nxt_irq_en = AVS_WRITEDATA_I[4:0];
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // unmapped words and the clear register read as zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (widx)
      `OFF_FLASH_CFG: begin
        nxt_rdata[`FLD_SOFT_RST] = soft_reset_bit_ff;
        nxt_rdata[`FLD_BANK_SEL] = bank_select_bit_ff;
      end
      `OFF_POWER_CTRL: begin
        nxt_rdata[`FLD_POWER_ON] = power_on_flag_ff;
      end
      `OFF_IRQ_EN_ONE: begin
        nxt_rdata[`FLD_BO_IRQ_EN] = brownout_irq_enable_ff;
      end
      `OFF_WDOG_CTRL: begin
        nxt_rdata[7:0] = wdog_ctrl_ff;
      end
      `OFF_IRQ_STATUS: begin
        nxt_rdata[4:0] = irq_sts_ff;
      end
      `OFF_IRQ_ENABLE: begin
        nxt_rdata[4:0] = irq_en_ff;
      end
      `OFF_LIVE: begin
        nxt_rdata[0] = bo_det;
        nxt_rdata[1] = ext_lvl;
        nxt_rdata[2] = FETCH_BOOT_O;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // register update
  // ---------------------------------------------------------------
  // power-on clears both bank bits and raises the power-on flag
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      soft_reset_bit_ff <= 1'b0;
      bank_select_bit_ff <= 1'b0;
      power_on_flag_ff <= 1'b1;
      brownout_irq_enable_ff <= 1'b0;
      wdog_ctrl_ff <= `RST_WDOG_CTRL;
      irq_sts_ff <= 5'h00;
      irq_en_ff <= 5'h00;
      bo_prev_ff <= 1'b0;
    end else begin
      soft_reset_bit_ff <= nxt_soft_reset_bit;
      bank_select_bit_ff <= nxt_bank_select_bit;
      power_on_flag_ff <= nxt_power_on_flag;
      brownout_irq_enable_ff <= nxt_brownout_irq_enable;
      wdog_ctrl_ff <= nxt_wdog_ctrl;
      irq_sts_ff <= nxt_irq_sts;
      irq_en_ff <= nxt_irq_en;
      bo_prev_ff <= bo_det;
    end
  end

  // ---------------------------------------------------------------
  // bus outputs
  // ---------------------------------------------------------------
  // waitrequest idles high and drops for exactly one cycle per
  // request, so read data is stable at the taking edge
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST_O <= ~(req & AVS_WAITREQUEST_O);
      if (req && AVS_WAITREQUEST_O) begin
        AVS_READDATA_O <= nxt_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // fetch path
  // ---------------------------------------------------------------
  // registered for timing, so the mapping lags the address by one
  // cycle; a bank change lands under code already in flight, which
  // is why software must not drop bank-select from low code
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      FETCH_BOOT_O <= 1'b0;
      FETCH_SECTOR_O <= 9'h000;
    end else begin
      FETCH_BOOT_O <= boot_sel(FETCH_ADDR_I, soft_reset_bit_ff,
        bank_select_bit_ff);
      FETCH_SECTOR_O <= FETCH_ADDR_I[15:`SECTOR_SHIFT];
    end
  end

  // ---------------------------------------------------------------
  // core reset and interrupts
  // ---------------------------------------------------------------
  // the core restarts at the reset vector; no port here reaches the
  // ram, so its contents ride through every running reset
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CPU_RESET_O <= 1'b1;
      BO_IRQ_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      CPU_RESET_O <= ext_lvl | hw_keep_reset | sw_reset;
      // held while enabled and low; the core vectors to 004BH
      BO_IRQ_O <= nxt_brownout_irq_enable & bo_det;
      IRQ_O <= |(nxt_irq_sts & nxt_irq_en);
    end
  end

endmodule // code_bank_reset_select

`default_nettype wire

//--- core/bank_consts.vh
/*
  constants for the code bank and reset selection block: register
  offsets, field positions, reset values and timing counts.
  assumes it is included by bare name from the top module and from bo_filter.
*/
`ifndef BANK_CONSTS_VH
`define BANK_CONSTS_VH

// ----------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------
`define OFF_FLASH_CFG 6'h00
`define OFF_POWER_CTRL 6'h01
`define OFF_IRQ_EN_ONE 6'h02
`define OFF_WDOG_CTRL 6'h03
`define OFF_IRQ_STATUS 6'h04
`define OFF_IRQ_CLEAR 6'h05
`define OFF_IRQ_ENABLE 6'h06
`define OFF_LIVE 6'h07

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FLD_BANK_SEL 0
`define FLD_SOFT_RST 1
`define FLD_POWER_ON 4
`define FLD_BO_IRQ_EN 3
`define FLD_WDOG_KEEP 2
`define EVT_BO_IRQ 0
`define EVT_BO_RST 1
`define EVT_WD_RST 2
`define EVT_SW_RST 3
`define EVT_EXT_RST 4
`define EVT_W 5

// ----------------------------------------------------------------
// reset values and memory map
// ----------------------------------------------------------------
`define RST_WDOG_CTRL 8'h00
`define RST_VECTOR 16'h0000
`define BO_VECTOR 16'h004b
`define BOOT_TOP 16'h1fff
`define SECTOR_SHIFT 7
`define SECTOR_W 9

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BO_MIN_CYCLES 4

`endif

//--- core/pin_sync.v
/*
  three flip-flop synchroniser for a pin level with an agreement
  check on the last two stages.
  assumes the pin is asynchronous to CLK_I.
*/
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire clk_i,
  input wire rst_i,
  input wire pin_i,
  output reg level_o
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  // ---------------------------------------------------------------
  // sync chain
  // ---------------------------------------------------------------
  // s1 feeds only s2; the level moves once s2 and s3 agree
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_o <= s3_ff;
      end
    end
  end

endmodule // pin_sync

`default_nettype wire

//--- core/bo_filter.v
/*
  persistence filter for the supply-low indication.
  assumes low_i is already synchronised to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bank_consts.vh"

module bo_filter #(
  parameter MIN_CYCLES = `BO_MIN_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire low_i,
  output reg det_o
);

  reg [3:0] cnt_ff;

  // ---------------------------------------------------------------
  // persistence counter
  // ---------------------------------------------------------------
  // any gap restarts the count, so short dips never reach det_o
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 4'h0;
      det_o <= 1'b0;
    end else if (!low_i) begin
      cnt_ff <= 4'h0;
      det_o <= 1'b0;
    end else begin
      if (cnt_ff < MIN_CYCLES[3:0]) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
      det_o <= (cnt_ff >= MIN_CYCLES[3:0] - 4'h1);
    end
  end

endmodule // bo_filter

`default_nettype wire

//--- test/code_bank_reset_select_properties.sv
/*
  checker for the code bank and reset selection block, bound to the
  top module ports.
  assumes one clock domain and an active high asynchronous RST_I.
*/
`timescale 1ns/1ns
`default_nettype none
module code_bank_reset_select_properties #(
  parameter BO_MIN = 4
) (
  input wire CLK_I,
  input wire RST_I,
  input wire RST_PIN_I,
  input wire SUPPLY_LOW_I,
  input wire WDOG_RESET_I,
  input wire [15:0] FETCH_ADDR_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire AVS_WAITREQUEST_O,
  input wire FETCH_BOOT_O,
  input wire [8:0] FETCH_SECTOR_O,
  input wire CPU_RESET_O,
  input wire BO_IRQ_O
);
  logic [3:0] low_cnt_ff;
  logic [3:0] nxt_low_cnt;
  // run length of supply-low; saturates so a long dip cannot wrap to 0
  assign nxt_low_cnt = !SUPPLY_LOW_I ? 4'h0 :
    (low_cnt_ff == 4'hf) ? low_cnt_ff : low_cnt_ff + 4'h1;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      low_cnt_ff <= 4'h0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sector_track_a: assert property (
    !$past(RST_I) |-> FETCH_SECTOR_O == $past(FETCH_ADDR_I[15:7]))
    else $error("sector does not follow the fetch address");
  boot_high_a: assert property (
    !$past(RST_I) && $past(FETCH_ADDR_I) > 16'h1fff |-> !FETCH_BOOT_O)
    else $error("boot block served above the low 8 kB");
  pin_core_a: assert property (
    RST_PIN_I [*8] |-> CPU_RESET_O)
    else $error("held reset pin does not hold the core in reset");
  pin_boot_a: assert property (
    RST_PIN_I [*8] ##0 FETCH_ADDR_I <= 16'h1fff |=> FETCH_BOOT_O)
    else $error("pin reset does not map the boot block low");
  wdog_core_a: assert property (
    WDOG_RESET_I |=> CPU_RESET_O)
    else $error("watchdog pulse gave no core restart");
  bo_filter_a: assert property (
    $rose(BO_IRQ_O) |-> low_cnt_ff >= BO_MIN)
    else $error("brownout interrupt after too short a dip");
  bus_answer_a: assert property (
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("bus request not answered after one wait state");
  bus_stand_a: assert property (
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
endmodule // code_bank_reset_select_properties
bind code_bank_reset_select code_bank_reset_select_properties #(
  .BO_MIN(BO_MIN)
) props (
  .CLK_I(CLK_I), .RST_I(RST_I), .RST_PIN_I(RST_PIN_I),
  .SUPPLY_LOW_I(SUPPLY_LOW_I), .WDOG_RESET_I(WDOG_RESET_I),
  .FETCH_ADDR_I(FETCH_ADDR_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .FETCH_BOOT_O(FETCH_BOOT_O), .FETCH_SECTOR_O(FETCH_SECTOR_O),
  .CPU_RESET_O(CPU_RESET_O), .BO_IRQ_O(BO_IRQ_O)
);
`default_nettype wire

//--- test/fetch_reset_partner.sv
/*
  far side model: core fetch unit and external reset circuit.
  assumes the bench supplies the next fetch address and pin request.
*/
`timescale 1ns/1ns
`default_nettype none
module fetch_reset_partner #(
  parameter HOLD_EXTRA = 2
) (
  input wire logic clk_i,
  input wire logic core_reset_i,
  input wire logic [15:0] next_addr_i,
  input wire logic pin_req_i,
  output var logic [15:0] fetch_addr_o = 16'h0000,
  output var logic rst_pin_o = 1'b0
);
  integer hold_ff = 0;
  // a restarted core fetches from 0000H first
  always @(posedge clk_i) begin
    fetch_addr_o <= core_reset_i ? 16'h0000 : next_addr_i;
  end
  // pin kept high two cycles past the request, as start-up needs
  always @(posedge clk_i) begin
    if (pin_req_i) begin
      hold_ff <= HOLD_EXTRA;
      rst_pin_o <= 1'b1;
    end else if (hold_ff > 0) begin
      hold_ff <= hold_ff - 1;
    end else begin
      rst_pin_o <= 1'b0;
    end
  end
endmodule // fetch_reset_partner
`default_nettype wire

//--- test/code_bank_reset_select_tb_top.sv
/*
  self-checking bench for the code bank and reset selection block.
  assumes the register map and timing of the designer's hand-over.
*/
`timescale 1ns/1ns
`default_nettype none
module code_bank_reset_select_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pin_req = 1'b0;
  logic sup_low = 1'b0;
  logic wdog = 1'b0;
  logic [15:0] next_addr = 16'h0000;
  logic [7:0] av_addr = 8'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] q;
  wire [31:0] rdata;
  wire [15:0] faddr;
  wire [8:0] sector;
  wire waitreq, boot, cpu_rst, bo_irq, irq, rst_pin;
  integer bad_count = 0;
  integer compares = 0;
  integer sw_m = 0, bk_m = 0, st = 0, n = 0;
  initial forever #50 clk = ~clk;
  code_bank_reset_select #(.BO_MIN(4)) dut (.CLK_I(clk), .RST_I(rst),
    .RST_PIN_I(rst_pin), .SUPPLY_LOW_I(sup_low), .WDOG_RESET_I(wdog),
    .FETCH_ADDR_I(faddr), .AVS_ADDRESS_I(av_addr), .AVS_READ_I(av_rd),
    .AVS_WRITE_I(av_wr), .AVS_WRITEDATA_I(av_wdata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .FETCH_BOOT_O(boot), .FETCH_SECTOR_O(sector), .CPU_RESET_O(cpu_rst),
    .BO_IRQ_O(bo_irq), .IRQ_O(irq));
  fetch_reset_partner partner (.clk_i(clk), .core_reset_i(cpu_rst),
    .next_addr_i(next_addr), .pin_req_i(pin_req), .fetch_addr_o(faddr),
    .rst_pin_o(rst_pin));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("compares=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // request held until waitrequest is sampled low, then released
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    @(posedge clk);
    av_addr <= a; av_wr <= w; av_rd <= !w; av_wdata <= d;
    do begin @(posedge clk); k++; end while (waitreq !== 1'b0 && k < 20);
    q = rdata;
    av_rd <= 1'b0; av_wr <= 1'b0;
    if (k >= 20) begin bad_count++; final_report; end
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0); check(q, e);
  endtask
  // model of the low 8 kB overlay compared on every fetch
  task fetch_chk(input integer cnt);
    logic [15:0] a;
    logic e;
    repeat (cnt) begin
      @(posedge clk); a = faddr; next_addr <= 16'($urandom); #1;
      e = a <= 16'h1fff && sw_m == 0 && bk_m == 0;
      check({31'h0, boot}, {31'h0, e});
      check({23'h0, sector}, {23'h0, a[15:7]});
    end
  endtask
  // the restart pulse lasts one cycle only
  task pulse_chk(input integer lim);
    integer k;
    k = 0; #1;
    while (cpu_rst !== 1'b1 && k < lim) begin @(posedge clk); #1; k++; end
    check({31'h0, cpu_rst}, 32'h1);
    @(posedge clk); #1; check({31'h0, cpu_rst}, 32'h0);
  endtask
  task wd_pulse;
    @(posedge clk); wdog <= 1'b1; @(posedge clk); wdog <= 1'b0;
  endtask
  task irq_chk(input logic e);
    repeat (2) @(posedge clk);
    #1; check({31'h0, irq}, {31'h0, e});
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h824713da));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    fetch_chk(30);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h10);
    bus(1'b1, 8'h40, 32'hffffffff);
    rd_chk(8'h40, 32'h0);
    $display("test reset_state done");
    bus(1'b1, 8'h0c, 32'hff); bus(1'b1, 8'h08, 32'h08);
    rd_chk(8'h0c, 32'hff);
    bus(1'b1, 8'h00, 32'h2); pulse_chk(4);
    sw_m = 1; st = st | 8;
    rd_chk(8'h00, 32'h2);
    rd_chk(8'h0c, 32'h04);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h04, 32'h10);
    fetch_chk(20);
    // software writes bank-select either way and a soft reset clears it; hardware resets clear it
    bus(1'b1, 8'h00, 32'h1); sw_m = 0; bk_m = 1;
    rd_chk(8'h00, 32'h1); fetch_chk(20);
    $display("test soft_reset done");
    wd_pulse; pulse_chk(4); bk_m = 0; st = st | 4;
    rd_chk(8'h00, 32'h0); fetch_chk(10);
    bus(1'b1, 8'h00, 32'h2); pulse_chk(4); sw_m = 1;
    bus(1'b1, 8'h00, 32'h3); wd_pulse; pulse_chk(4);
    rd_chk(8'h00, 32'h2); fetch_chk(10);
    bus(1'b1, 8'h04, 32'h0); rd_chk(8'h04, 32'h0);
    bus(1'b1, 8'h04, 32'h10); rd_chk(8'h04, 32'h0);
    $display("test watchdog done");
    bus(1'b1, 8'h08, 32'h08); bus(1'b1, 8'h00, 32'h3);
    @(posedge clk); sup_low <= 1'b1;
    repeat (3) @(posedge clk);
    sup_low <= 1'b0;
    repeat (10) @(posedge clk);
    #1; check({31'h0, bo_irq}, 32'h0);
    rd_chk(8'h10, st);
    @(posedge clk); sup_low <= 1'b1;
    n = 0;
    while (bo_irq !== 1'b1 && n < 15) begin @(posedge clk); #1; n++; end
    check({31'h0, bo_irq}, 32'h1); st = st | 1;
    bus(1'b1, 8'h08, 32'h0); pulse_chk(4); bk_m = 0; st = st | 2;
    rd_chk(8'h00, 32'h2);
    @(posedge clk); sup_low <= 1'b0;
    bus(1'b1, 8'h00, 32'h3); bk_m = 1;
    repeat (10) @(posedge clk);
    sup_low <= 1'b1; pulse_chk(15); bk_m = 0;
    rd_chk(8'h00, 32'h2);
    @(posedge clk); sup_low <= 1'b0;
    repeat (10) @(posedge clk);
    $display("test brownout done");
    rd_chk(8'h10, st); rd_chk(8'h14, 32'h0);
    bus(1'b1, 8'h18, 32'h0); irq_chk(1'b0);
    bus(1'b1, 8'h18, 32'h4); irq_chk(1'b1);
    bus(1'b1, 8'h14, 32'h4); st = st & 32'h1b; irq_chk(1'b0);
    rd_chk(8'h10, st);
    bus(1'b1, 8'h18, 32'h1f); irq_chk(1'b1);
    bus(1'b1, 8'h14, 32'h1f); irq_chk(1'b0);
    $display("test interrupt done");
    @(posedge clk); pin_req <= 1'b1;
    repeat (4) @(posedge clk);
    wd_pulse; repeat (4) @(posedge clk);
    #1; check({31'h0, cpu_rst}, 32'h1);
    pin_req <= 1'b0; n = 0;
    while (cpu_rst !== 1'b0 && n < 15) begin @(posedge clk); #1; n++; end
    sw_m = 0; bk_m = 0;
    rd_chk(8'h00, 32'h0); fetch_chk(20);
    // the watchdog pulse fell inside the pin reset, so only bit4 marks
    rd_chk(8'h10, 32'h10);
    rd_chk(8'h04, 32'h0);
    $display("test pin_reset done");
    final_report;
  end
  initial begin
    #(3000 * 100);
    bad_count++;
    final_report;
  end
endmodule // code_bank_reset_select_tb_top
`default_nettype wire
